// ### serial_port_pkg.sv
// Shared constants and types for the four-wire serial command port.
// Both ends and the testbench import this package; nothing else is assumed.
package serial_port_pkg;

  // Line rate that the mode/loop-back register selects.
  typedef enum logic [1:0] {
    RATE_DS3,
    RATE_STS1,
    RATE_E3
  } rate_t;

  // Loop-back mode decoded from the two loop bits.
  typedef enum logic [1:0] {
    LOOP_NONE,
    LOOP_REMOTE,
    LOOP_ANALOG,
    LOOP_DIGITAL
  } loop_t;

  // Bit positions inside the mode/loop-back register.
  localparam int FAR_LOOP_BIT   = 0;
  localparam int NEAR_LOOP_BIT  = 1;
  localparam int E3_SEL_BIT     = 2;
  localparam int STS1_SEL_BIT   = 3;
  localparam int UNUSED_BIT     = 4;
  localparam int CTRL_WIDTH     = 5;

  // Register address and value after reset.
  localparam logic [3:0] MODE_LOOPBACK_ADDR  = 4'h4;
  localparam logic [3:0] MODE_LOOPBACK_RESET = 4'h0;

  // Frame layout: header bits then data bits, both sent LSB first.
  localparam int HEADER_BITS = 8;
  localparam int DATA_BITS   = 8;
  localparam int FRAME_BITS  = HEADER_BITS + DATA_BITS;
  localparam int ADDR_FIRST  = 1;
  localparam int ADDR_LAST   = 4;

  // Timing: system clock and the serial clock the host divides from it.
  localparam int CLK_NS        = 4;
  localparam int SCLK_NS       = 160;
  localparam int SCLK_HALF_CYC = SCLK_NS / CLK_NS / 2;
  localparam int CS_LEAD_NS    = 5;
  localparam int CS_LEAD_CYC   = (CS_LEAD_NS + CLK_NS - 1) / CLK_NS;

endpackage

// ### serial_port_if.sv
// Four-wire serial command port wires between host and device.
// The serial data output is a driven pin; the wire reads low when undriven.
`timescale 1ns/10ps
interface serial_port_if;
  logic cs_n;                 // Active-low select from the host.
  logic sclk;                 // Serial clock from the host.
  logic serial_data_in;       // Host to device data.
  logic serial_data_out_q;    // Device output value.
  logic serial_data_out_oe;   // Device output enable.
  logic serial_data_out;      // Resolved wire level.

  // Without a driver the line is pulled low.
  assign serial_data_out = serial_data_out_oe & serial_data_out_q;

  modport host (
    output cs_n,
    output sclk,
    output serial_data_in,
    input  serial_data_out
  );

  modport dev (
    input  cs_n,
    input  sclk,
    input  serial_data_in,
    output serial_data_out_q,
    output serial_data_out_oe
  );
endinterface

// ### serial_host.sv
// Host end of the serial command port: runs one frame per start request.
// Assumes the device samples data on rising serial clock edges.
`timescale 1ns/10ps
module serial_host
  import serial_port_pkg::*;
#(
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  input  wire logic       clk_i,     // System clock.
  input  wire logic       rst_i,     // Synchronous reset, high.
  serial_port_if.host     port,      // Serial pins.
  input  wire logic       start_i,   // Pulse: begin a frame.
  input  wire logic       read_i,    // 1 read, 0 write.
  input  wire logic [3:0] addr_i,    // Register address.
  input  wire logic [7:0] wdata_i,   // Write data.
  output logic            busy_o,    // Frame in progress.
  output logic            done_o,    // Pulse: frame finished.
  output logic [7:0]      rdata_o    // Data read back.
);

  typedef enum logic [2:0] {
    H_IDLE,
    H_LEAD,
    H_HIGH,
    H_LOW,
    H_TAIL,
    H_GAP
  } hstate_t;

  hstate_t         state_r;
  logic [15:0]     tx_r;
  logic [7:0]      rx_r;
  logic [3:0]      bit_r;
  logic [7:0]      tmr_r;
  logic            cs_n_r;
  logic            sclk_r;
  logic            din_r;
  logic            dout_m_r;
  logic            dout_s_r;
  logic [15:0]     frame_w;
  logic            tmr_end_w;
  logic [7:0]      rx_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Frame word: direction, address LSB first, two zero pads, spare, data.
  assign frame_w   = {wdata_i, 1'b0, 2'b00, addr_i, read_i};
  assign tmr_end_w = (tmr_r == 8'(HALF_CYC - 1));
  assign rx_nxt    = {dout_s_r, rx_r[7:1]};

  // The device output is a pin from another domain, so it is synchronised.
  always_ff @(posedge clk_i) begin
    dout_m_r <= port.serial_data_out;
    dout_s_r <= dout_m_r;
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider and sequencer; the half-period lead also covers the select setup.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= H_IDLE;
      tx_r    <= 16'h0000;
      rx_r    <= 8'h00;
      bit_r   <= 4'h0;
      tmr_r   <= 8'h00;
      cs_n_r  <= 1'b1;
      sclk_r  <= 1'b0;
      din_r   <= 1'b0;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
      rdata_o <= 8'h00;
    end else begin
      done_o <= 1'b0;
      tmr_r  <= tmr_end_w ? 8'h00 : tmr_r + 8'h01;
      unique case (state_r)
        H_IDLE: begin
          tmr_r <= 8'h00;
          if (start_i) begin
            tx_r    <= frame_w;
            din_r   <= frame_w[0];
            cs_n_r  <= 1'b0;
            bit_r   <= 4'h0;
            busy_o  <= 1'b1;
            state_r <= H_LEAD;
          end
        end
        H_LEAD: begin
          if (tmr_end_w) begin
            sclk_r  <= 1'b1;
            state_r <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (tmr_end_w) begin
            sclk_r <= 1'b0;
            rx_r   <= rx_nxt;
            if (bit_r == 4'(FRAME_BITS - 1)) begin
              state_r <= H_TAIL;
            end else begin
              tx_r    <= {1'b0, tx_r[15:1]};
              din_r   <= tx_r[1];
              bit_r   <= bit_r + 4'h1;
              state_r <= H_LOW;
            end
          end
        end
        H_LOW: begin
          if (tmr_end_w) begin
            sclk_r  <= 1'b1;
            state_r <= H_HIGH;
          end
        end
        H_TAIL: begin
          if (tmr_end_w) begin
            cs_n_r  <= 1'b1;
            state_r <= H_GAP;
          end
        end
        H_GAP: begin
          if (tmr_end_w) begin
            busy_o  <= 1'b0;
            done_o  <= 1'b1;
            rdata_o <= rx_r;
            state_r <= H_IDLE;
          end
        end
      endcase
    end
  end

  assign port.cs_n           = cs_n_r;
  assign port.sclk           = sclk_r;
  assign port.serial_data_in = din_r;

endmodule

// ### serial_device.sv
// Device end of the serial command port with the mode/loop-back register.
// Assumes the host makes the serial clock far slower than the system clock.
//
// Contract
// - D3 picks DS3 (0) or STS-1 (1).
// - E3 bit set overrides the DS3/STS-1 choice.
// - E3 bit 1 gives E3, 0 keeps D3.
// - Loop bits decode normal, remote, analog, digital.
// - Host must supply the serial clock.
// - Falling select starts a new transfer.
// - Eight header bits follow select assertion.
// - Data sampled on rising serial clock edges.
// - First header bit: 1 read, 0 write.
// - Next four bits carry the register address.
// - Host sends address bits LSB first.
// - Host sends both pad bits as zero.
// - Top register bit ignores writes.
`timescale 1ns/10ps
module serial_device
  import serial_port_pkg::*;
(
  input  wire logic  clk_i,          // System clock.
  input  wire logic  rst_i,          // Synchronous reset, high.
  serial_port_if.dev port,           // Serial pins.
  output rate_t      line_rate_o,    // Selected line rate.
  output loop_t      loop_mode_o,    // Selected loop-back mode.
  output logic       near_loop_o,    // Near-end loop bit.
  output logic       far_loop_o      // Far-end loop bit.
);

  typedef enum logic [1:0] {
    D_IDLE,
    D_HEAD,
    D_DATA
  } dstate_t;

  // Synchroniser stages; the first stage of each feeds only the second.
  logic            cs_m_r;
  logic            cs_s_r;
  logic            cs_d_r;
  logic            sclk_m_r;
  logic            sclk_s_r;
  logic            sclk_d_r;
  logic            din_m_r;
  logic            din_s_r;

  // Transfer state.
  dstate_t         state_r;
  logic [3:0]      cnt_r;
  logic            dir_r;
  logic [3:0]      addr_r;
  logic [1:0]      pad_r;
  logic [7:0]      wsh_r;
  logic [7:0]      rsh_r;
  logic            dout_r;
  logic            dout_oe_r;

  // Register and decoded outputs.
  logic [3:0]      ctrl_r;
  rate_t           rate_r;
  loop_t           loop_r;
  logic            near_r;
  logic            far_r;

  // Decode wires.
  logic            rise_w;
  logic            fall_w;
  logic            cs_fall_w;
  logic            cs_high_w;
  logic            last_head_w;
  logic            last_data_w;
  logic [7:0]      wsh_nxt;
  logic            hit_w;
  logic            pads_ok_w;
  logic            commit_w;
  logic [7:0]      rdata_w;
  rate_t           rate_w;
  loop_t           loop_w;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge history.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_m_r   <= 1'b1;
      cs_s_r   <= 1'b1;
      cs_d_r   <= 1'b1;
      sclk_m_r <= 1'b0;
      sclk_s_r <= 1'b0;
      sclk_d_r <= 1'b0;
      din_m_r  <= 1'b0;
      din_s_r  <= 1'b0;
    end else begin
      cs_m_r   <= port.cs_n;
      cs_s_r   <= cs_m_r;
      cs_d_r   <= cs_s_r;
      sclk_m_r <= port.sclk;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
      din_m_r  <= port.serial_data_in;
      din_s_r  <= din_m_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Edge detection; data and clock pass equal stages so they stay aligned.
  assign rise_w      = sclk_s_r & ~sclk_d_r;
  assign fall_w      = ~sclk_s_r & sclk_d_r;
  assign cs_fall_w   = ~cs_s_r & cs_d_r;
  assign cs_high_w   = cs_s_r;
  assign last_head_w = (cnt_r == 4'(HEADER_BITS - 1));
  assign last_data_w = (cnt_r == 4'(FRAME_BITS - 1));
  assign wsh_nxt     = {din_s_r, wsh_r[7:1]};

  // Address match and write qualification; a frame with nonzero pads is
  // treated as malformed and never alters the register.
  assign hit_w     = (addr_r == MODE_LOOPBACK_ADDR);
  assign pads_ok_w = (pad_r == 2'b00);
  assign commit_w  = (state_r == D_DATA) & rise_w & last_data_w & ~dir_r & hit_w & pads_ok_w;

  // Readback: the unused top bit and unmapped addresses read as zero.
  assign rdata_w = hit_w ? {3'b000, 1'b0, ctrl_r} : 8'h00;

  // Rate selection: E3 overrides, otherwise D3 picks DS3 or STS-1.
  assign rate_w = ctrl_r[E3_SEL_BIT]   ? RATE_E3 :
                  ctrl_r[STS1_SEL_BIT] ? RATE_STS1 :
                                         RATE_DS3;

  // Loop-back selection from the two loop bits taken together.
  assign loop_w = loop_t'({ctrl_r[NEAR_LOOP_BIT], ctrl_r[FAR_LOOP_BIT]});

  ////////////////////////////////////////////////////////////////////////
  // Header and data sequencing. Released select always wins and aborts,
  // so a fresh falling select, which always follows a release, starts a transfer from idle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= D_IDLE;
      cnt_r   <= 4'h0;
      dir_r   <= 1'b0;
      addr_r  <= 4'h0;
      pad_r   <= 2'b00;
      wsh_r   <= 8'h00;
    end else if (cs_high_w) begin
      state_r <= D_IDLE;
      cnt_r   <= 4'h0;
    end else if (cs_fall_w) begin
      state_r <= D_HEAD;
      cnt_r   <= 4'h0;
    end else if (rise_w && state_r != D_IDLE) begin
      cnt_r <= cnt_r + 4'h1;
      if (state_r == D_HEAD) begin
        if (cnt_r == 4'h0) begin
          dir_r <= din_s_r;
        end else if (cnt_r <= 4'(ADDR_LAST)) begin
          addr_r <= {din_s_r, addr_r[3:1]};
        end else if (cnt_r <= 4'(ADDR_LAST + 2)) begin
          pad_r <= {din_s_r, pad_r[1]};
        end
        if (last_head_w) begin
          state_r <= D_DATA;
        end
      end else begin
        wsh_r <= wsh_nxt;
        if (last_data_w) begin
          state_r <= D_IDLE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data: loaded after the header, shifted out on each falling edge so
  // that every bit is stable across the host's next rising edge. The output
  // stays enabled after the last bit until select is released.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsh_r     <= 8'h00;
      dout_r    <= 1'b0;
      dout_oe_r <= 1'b0;
    end else if (cs_high_w || cs_fall_w) begin
      dout_r    <= 1'b0;
      dout_oe_r <= 1'b0;
    end else if (state_r == D_HEAD && rise_w && last_head_w) begin
      rsh_r <= rdata_w;
    end else if (fall_w && dir_r && (state_r == D_DATA || dout_oe_r)) begin
      dout_r    <= rsh_r[0];
      dout_oe_r <= 1'b1;
      rsh_r     <= {1'b0, rsh_r[7:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode/loop-back register; the top data bit is never stored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= MODE_LOOPBACK_RESET;
    end else if (commit_w) begin
      ctrl_r <= wsh_nxt[3:0];
    end
  end

  // Registered mode outputs follow the register one cycle later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_r <= RATE_DS3;
      loop_r <= LOOP_NONE;
      near_r <= 1'b0;
      far_r  <= 1'b0;
    end else begin
      rate_r <= rate_w;
      loop_r <= loop_w;
      near_r <= ctrl_r[NEAR_LOOP_BIT];
      far_r  <= ctrl_r[FAR_LOOP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output connections, all straight from flip-flops.
  assign port.serial_data_out_q  = dout_r;
  assign port.serial_data_out_oe = dout_oe_r;
  assign line_rate_o             = rate_r;
  assign loop_mode_o             = loop_r;
  assign near_loop_o             = near_r;
  assign far_loop_o              = far_r;

endmodule

// ### serial_port_asserts.sv
// Concurrent checks on the wires between the serial host and the serial device.
// Assumes a host half period of four system clocks and inputs tied to one interface.
`timescale 1ns/10ps
module serial_port_asserts (
  input wire logic clk_i,              // System clock.
  input wire logic rst_i,              // Synchronous reset, high.
  input wire logic cs_n,               // Active-low select.
  input wire logic sclk,               // Serial clock.
  input wire logic serial_data_in,     // Host to device data.
  input wire logic serial_data_out_q,  // Device output value.
  input wire logic serial_data_out_oe, // Device output enable.
  input wire logic serial_data_out     // Resolved output wire.
);
  logic       sclk_q_r;
  logic [4:0] rises_r;
  logic [4:0] rises_nxt;
  wire        sclk_rise;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Rises since select fell; cleared while deselected so an abort cannot leak a count.
  assign sclk_rise = sclk & ~sclk_q_r;
  assign rises_nxt = cs_n ? 5'h00 : rises_r + {4'h0, sclk_rise};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_q_r <= 1'b0;
      rises_r  <= 5'h00;
    end else begin
      sclk_q_r <= sclk;
      rises_r  <= rises_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Framing and serial clock shape.
  property p_sclk_idle; cs_n |-> !sclk; endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("Serial clock high while deselected.");
  property p_cs_lead; $fell(cs_n) |-> (!sclk)[*4]; endproperty
  a_cs_lead: assert property (p_cs_lead) else $error("Serial clock rose too soon after select.");
  property p_sclk_high; $rose(sclk) |-> sclk[*4]; endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("Serial clock high phase too short.");
  property p_din_hold; sclk && $past(sclk) |-> $stable(serial_data_in); endproperty
  a_din_hold: assert property (p_din_hold) else $error("Input data moved while clock high.");
  property p_frame_len; $rose(cs_n) |-> rises_r == 5'd16; endproperty
  a_frame_len: assert property (p_frame_len) else $error("Frame did not carry sixteen rises.");

  // Read data only follows the eight header bits and stops after release.
  property p_oe_after_header; $rose(serial_data_out_oe) |-> rises_r == 5'd8 && !cs_n; endproperty
  a_oe_after_header: assert property (p_oe_after_header) else $error("Output enabled off header end.");
  property p_oe_release; cs_n[*6] |-> !serial_data_out_oe; endproperty
  a_oe_release: assert property (p_oe_release) else $error("Output still driven after release.");
  property p_dout_stable; serial_data_out_oe && sclk && $past(sclk) |-> $stable(serial_data_out_q); endproperty
  a_dout_stable: assert property (p_dout_stable) else $error("Output data moved while clock high.");

  c_read: cover property ($rose(serial_data_out_oe));
  c_frame: cover property ($rose(cs_n) && rises_r == 5'd16);
  c_dout_one: cover property (serial_data_out);
endmodule

// ### serial_cmd_port_mode_loopback_tb.sv
// Self-checking bench: host and device joined by one interface, plus a driven device.
// Assumes the design package, interface, host and device are compiled first.
`timescale 1ns/10ps
module serial_cmd_port_mode_loopback_tb
  import serial_port_pkg::*;
;
  typedef struct packed { logic [7:0] wd; rate_t rate; loop_t loop; } row_t;
  localparam int H = 4;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        start = 1'b0;
  logic        rd_sel = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [7:0]  wdata = 8'h00;
  logic        busy_o, done_o, near_a, far_a, near_b, far_b;
  logic [7:0]  rdata_o;
  rate_t       rate_a, rate_b;
  loop_t       loop_a, loop_b;
  logic        sclk_q = 1'b0;
  logic        cs_q = 1'b1;
  logic [4:0]  mon_cnt = 5'h00;
  logic [15:0] mon_bits = 16'h0000;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  row_t rows [8] = '{'{8'h00, RATE_DS3, LOOP_NONE}, '{8'h01, RATE_DS3, LOOP_REMOTE},
    '{8'h02, RATE_DS3, LOOP_ANALOG}, '{8'h03, RATE_DS3, LOOP_DIGITAL}, '{8'h08, RATE_STS1, LOOP_NONE},
    '{8'h04, RATE_E3, LOOP_NONE}, '{8'h0d, RATE_E3, LOOP_REMOTE}, '{8'h1e, RATE_E3, LOOP_ANALOG}};

  serial_port_if ifa ();
  serial_port_if ifb ();
  serial_host #(.HALF_CYC(H)) u_serial_host (.clk_i(clk_i), .rst_i(rst_i), .port(ifa), .start_i(start),
    .read_i(rd_sel), .addr_i(addr), .wdata_i(wdata), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o));
  serial_device u_serial_device (.clk_i(clk_i), .rst_i(rst_i), .port(ifa), .line_rate_o(rate_a),
    .loop_mode_o(loop_a), .near_loop_o(near_a), .far_loop_o(far_a));
  serial_device u_serial_device_b (.clk_i(clk_i), .rst_i(rst_i), .port(ifb), .line_rate_o(rate_b),
    .loop_mode_o(loop_b), .near_loop_o(near_b), .far_loop_o(far_b));
  serial_port_asserts u_serial_port_asserts (.clk_i(clk_i), .rst_i(rst_i), .cs_n(ifa.cs_n), .sclk(ifa.sclk),
    .serial_data_in(ifa.serial_data_in), .serial_data_out_q(ifa.serial_data_out_q),
    .serial_data_out_oe(ifa.serial_data_out_oe), .serial_data_out(ifa.serial_data_out));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and a cycle ceiling well above the few thousand cycles the run needs.
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      results();
    end
  end

  // Wire monitor: records the data bit at each serial clock rise of a frame.
  always @(posedge clk_i) begin
    sclk_q <= ifa.sclk;
    cs_q   <= ifa.cs_n;
    if (!ifa.cs_n && cs_q) begin
      mon_cnt <= 5'h00;
    end else if (ifa.sclk && !sclk_q) begin
      mon_bits[mon_cnt[3:0]] <= ifa.serial_data_in;
      mon_cnt <= mon_cnt + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task check(input logic [7:0] seen, input logic [7:0] exp);
    begin
      comparisons++;
      if (seen !== exp) begin
        fail_count++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task results;
    begin
      $display("Checks %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask

  // One host frame, then the wire contents are compared with what was asked for.
  task frame(input logic rd, input logic [3:0] a, input logic [7:0] d);
    int n;
    logic sb;
    begin
      n = 0;
      sb = 1'b0;
      @(posedge clk_i);
      start  <= 1'b1;
      rd_sel <= rd;
      addr   <= a;
      wdata  <= d;
      @(posedge clk_i);
      start <= 1'b0;
      while (done_o !== 1'b1 && n < 1000) begin
        @(posedge clk_i);
        #1;
        n++;
        sb = sb | busy_o;
      end
      check(8'(n == 1000), 8'h00);
      // Lead, sixteen high and fifteen low phases, tail and gap, each a half period long.
      check(8'(n), 8'((2 * FRAME_BITS + 2) * H));
      check({6'h00, sb, busy_o}, 8'h02);
      check(8'(mon_cnt), 8'h10);
      check({7'h00, mon_bits[0]}, {7'h00, rd});
      check({4'h0, mon_bits[4:1]}, {4'h0, a});
      check({6'h00, mon_bits[6:5]}, 8'h00);
      check(mon_bits[15:8], d);
    end
  endtask

  // Drives the second device by hand at the 160 ns link period; n below sixteen cuts the frame short.
  task bb(input logic [15:0] f, input int n);
    begin
      @(posedge clk_i);
      ifb.cs_n <= 1'b0;
      for (int i = 0; i < n; i++) begin
        repeat (SCLK_HALF_CYC / 2) @(posedge clk_i);
        ifb.serial_data_in <= f[i];
        repeat (SCLK_HALF_CYC / 2) @(posedge clk_i);
        ifb.sclk <= 1'b1;
        repeat (SCLK_HALF_CYC) @(posedge clk_i);
        ifb.sclk <= 1'b0;
      end
      repeat (SCLK_HALF_CYC) @(posedge clk_i);
      ifb.cs_n <= 1'b1;
      ifb.serial_data_in <= ~ifb.serial_data_in;
      repeat (2 * SCLK_HALF_CYC) @(posedge clk_i);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: table of writes with readback, then the awkward cases.
  initial begin
    ifb.cs_n = 1'b1;
    ifb.sclk = 1'b0;
    ifb.serial_data_in = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      frame(1'b0, MODE_LOOPBACK_ADDR, rows[i].wd);
      check(8'(rate_a), 8'(rows[i].rate));
      check(8'(loop_a), 8'(rows[i].loop));
      check({6'h00, near_a, far_a}, {6'h00, rows[i].wd[1:0]});
      frame(1'b1, MODE_LOOPBACK_ADDR, 8'h00);
      check(rdata_o, {4'h0, rows[i].wd[3:0]});
    end
    // Another address neither takes a write nor returns the register.
    frame(1'b0, 4'h3, 8'h00);
    check(8'(rate_a), 8'(RATE_E3));
    frame(1'b1, 4'h3, 8'h00);
    check(rdata_o, 8'h00);
    // Reset in mid-run returns the register to DS3 with no loop.
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    check(8'(rate_a), 8'(RATE_DS3));
    check(8'(loop_a), 8'(LOOP_NONE));
    frame(1'b1, MODE_LOOPBACK_ADDR, 8'h00);
    check(rdata_o, 8'h00);
    // Hand-driven frames: bad pad bits, an abort before commit, then a clean restart.
    bb({8'h0b, 1'b0, 2'b01, MODE_LOOPBACK_ADDR, 1'b0}, 16);
    check(8'(rate_b), 8'(RATE_DS3));
    bb({8'h0b, 1'b0, 2'b00, MODE_LOOPBACK_ADDR, 1'b0}, 15);
    check(8'(loop_b), 8'(LOOP_NONE));
    bb({8'h0b, 1'b0, 2'b00, MODE_LOOPBACK_ADDR, 1'b0}, 16);
    check(8'(rate_b), 8'(RATE_STS1));
    check({6'h00, near_b, far_b}, 8'h03);
    check(8'(loop_b), 8'(LOOP_DIGITAL));
    results();
  end
endmodule
